// ==== logic/des_pkg.sv ====
// Purpose: Shared constants and types for the disk status encoder
// Assumes: 40 MHz ref_clk, one clock domain
// Notes:   Status codes are ASCII digits built from an error number
package des_pkg;
   // Clock rate and hardware watchdog
   localparam int unsigned CLK_KHZ      = 40000; // ref_clk in kHz
   localparam int unsigned TIMER_MS     = 500; // Watchdog time, ms
   localparam int unsigned TIMEOUT_CYC  = TIMER_MS * CLK_KHZ; // Watchdog in cycles

   // Geometry and retry policy
   localparam logic [15:0] DISK_SECTORS = 16'h07D2; // Sectors per disk (2002)
   localparam logic [15:0] SECTOR_BYTES = 16'h0080; // Bytes per sector
   localparam logic [2:0]  READ_TRIES   = 3'h5; // Attempts per sector

   // Status encoding
   localparam logic [7:0]  ASCII_ZERO   = 8'h30; // ASCII '0'
   localparam logic [7:0]  CODE_RESET   = 8'h30; // Code after reset

   // Error numbers
   localparam logic [3:0]  ERR_NONE     = 4'h0; // Clean completion
   localparam logic [3:0]  ERR_DATA_CRC = 4'h1; // Data check failure
   localparam logic [3:0]  ERR_WPROT    = 4'h2; // Write protected
   localparam logic [3:0]  ERR_NREADY   = 4'h3; // Drive not ready
   localparam logic [3:0]  ERR_DELETED  = 4'h4; // Deleted data mark
   localparam logic [3:0]  ERR_TIMEOUT  = 4'h5; // Watchdog or abort
   localparam logic [3:0]  ERR_BAD_ADDR = 4'h6; // Range beyond disk
   localparam logic [3:0]  ERR_SEEK     = 4'h7; // Seek or return fault
   localparam logic [3:0]  ERR_NO_MARK  = 4'h8; // Data mark missing

   // Operation kinds requested by the host
   typedef enum logic [2:0] {
      DES_OP_READ    = 3'h0, // Read to memory
      DES_OP_WRITE   = 3'h1, // Write from memory
      DES_OP_WVERIFY = 3'h2, // Write then verify
      DES_OP_READ_WRITE_TEST_OP  = 3'h3, // Read/write test
      DES_OP_HRETURN = 3'h4  // Head return to track 0
   } des_op_e;
endpackage

// ==== logic/des_tmr.sv ====
// Purpose: Watchdog timer for one disk operation
// Assumes: run is held high for the whole operation
// Notes:   expired stays high until run falls
`timescale 1ns/10ps
module des_tmr #(
   parameter int unsigned CYCLES = des_pkg::TIMEOUT_CYC      // Watchdog length
) (
   input  wire logic ref_clk,                                 // System clock
   input  wire logic srst,                                    // Sync reset, high
   input  wire logic run,                                     // Count while high
   output logic      expired                                  // Watchdog has run out
);
   // Timer state
   typedef struct packed {
      logic [31:0] count;                                     // Cycles elapsed
      logic        expired;                                   // Run-out flag
   } des_tmr_s;

   des_tmr_s st;                                              // Registered state
   des_tmr_s next_st;                                         // Next state

   // Count while running, clear when idle
   always_comb
   begin
      next_st = st;
      if (!run)
      begin
         next_st.count   = '0;
         next_st.expired = 1'b0;
      end
      else if (st.count >= CYCLES - 1)
         next_st.expired = 1'b1;                              // Sticky until run falls
      else
         next_st.count = st.count + 32'h1;
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end

   assign expired = st.expired;
endmodule

// ==== logic/des_enc.sv ====
// Purpose: Status code and carry holder
// Assumes: load pulses once at the end of each operation
// Notes:   Outputs come straight from flip-flops
`timescale 1ns/10ps
module des_enc (
   input  wire logic       ref_clk,                           // System clock
   input  wire logic       srst,                              // Sync reset, high
   input  wire logic       load,                              // Capture a result
   input  wire logic [3:0] err_num,                           // Error number 0..9
   output logic      [7:0] status_code,                       // ASCII status digit
   output logic            carry                              // Set on any error
);
   // Held result
   typedef struct packed {
      logic [7:0] code;                                       // ASCII code
      logic       carry;                                      // Error flag
   } des_enc_s;

   des_enc_s st;                                              // Registered state
   des_enc_s next_st;                                         // Next state

   // Encode on load, hold otherwise
   always_comb
   begin
      next_st = st;
      if (load)
      begin
         next_st.code  = des_pkg::ASCII_ZERO + {4'h0, err_num};
         next_st.carry = (err_num != des_pkg::ERR_NONE);
      end
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         st.code  <= des_pkg::CODE_RESET;
         st.carry <= 1'b0;
      end
      else
         st <= next_st;
   end

   assign status_code = st.code;
   assign carry       = st.carry;
endmodule

// ==== logic/des_ctrl.sv ====
// Purpose: Disk operation sequencer with status encoding
// Assumes: Data path and seek logic answer with one-cycle pulses
// Notes:   One operation at a time; start is ignored while busy
`timescale 1ns/10ps
// Overview of operation
// - Clean finish gives code 30h, carry clear
// - Data check failure gives 31h, carry set
// - Pointer not advanced on data check failure
// - Five read attempts before data check error
// - Write to protected disk refused, 32h
// - Drive not ready at start gives 33h
// - Deleted data mark gives 34h
// - Deleted sector not transferred, pointer held
// - Watchdog expiry gives 35h
// - Abort interrupt ends operation with 35h
// - Any error stops operation at once
// - Range beyond disk gives 36h, not head-return
// - Seek or head-return fault gives 37h
// - Missing data mark after five tries, 38h
module des_ctrl #(
   parameter int unsigned TIMEOUT_CYCLES = des_pkg::TIMEOUT_CYC  // Watchdog cycles
) (
   input  wire logic        ref_clk,             // System clock 40 MHz
   input  wire logic        srst,                // Sync reset, high
   input  wire logic        op_start,            // Start pulse from host
   input  wire logic [2:0]  op_kind,             // Operation kind
   input  wire logic [15:0] first_sector_number, // First sector
   input  wire logic [15:0] sector_count,        // Sectors to do
   input  wire logic [15:0] start_address,       // Initial pointer
   input  wire logic        drive_ready,         // Drive ready level
   input  wire logic        write_protect,       // Write-protect level
   input  wire logic        track_zero,          // Track 0 sensor level
   input  wire logic        seek_done,           // Seek finished pulse
   input  wire logic        seek_fail,           // Seek fault with done
   input  wire logic        sect_done,           // Sector attempt done
   input  wire logic        sect_no_mark,        // No data mark found
   input  wire logic        sect_deleted,        // Deleted data mark
   input  wire logic        sect_crc_bad,        // Data check mismatch
   input  wire logic        abort_nmi,           // Abort interrupt pulse
   output logic             busy,                // Operation running
   output logic             op_done,             // Result ready pulse
   output logic [7:0]       op_status_code,      // ASCII status
   output logic             carry_flag,          // Error flag
   output logic [15:0]      transfer_pointer,    // Memory address
   output logic             seek_req,            // Seek request pulse
   output logic             sect_req,            // Sector attempt pulse
   output logic [15:0]      sect_addr,           // Sector being handled
   output logic             sect_write,          // Attempt is a write
   output logic             sect_commit,         // Sector data accepted
   output logic             op_halt              // Stop data path pulse
);
   // Sequencer states, Gray along the normal path except the FINISH to IDLE step
   typedef enum logic [2:0] {
      DES_IDLE   = 3'b000,                                    // Waiting for start
      DES_CHECK  = 3'b001,                                    // Entry checks
      DES_SEEK   = 3'b011,                                    // Waiting on seek
      DES_REQ    = 3'b010,                                    // Issue sector attempt
      DES_WAIT   = 3'b110,                                    // Waiting on sector
      DES_FINISH = 3'b111                                     // Load result
   } des_state_e;

   // All controller state
   typedef struct packed {
      des_state_e  fsm;                                       // Sequencer state
      logic [2:0]  kind;                                      // Latched operation
      logic [15:0] sector;                                    // Current sector
      logic [15:0] remain;                                    // Sectors left
      logic [15:0] pointer;                                   // Transfer pointer
      logic [2:0]  tries;                                     // Attempts used
      logic [3:0]  err;                                       // Result number
      logic        busy;                                      // Running flag
      logic        done;                                      // Done pulse
      logic        seek_req;                                  // Seek pulse
      logic        sect_req;                                  // Sector pulse
      logic        commit;                                    // Commit pulse
      logic        halt;                                      // Halt pulse
   } des_ctrl_s;

   des_ctrl_s st;                                             // Registered state
   des_ctrl_s next_st;                                        // Next state
   logic      tmr_expired;                                    // Watchdog run out

   // Writes cover plain write, verify and test kinds
   function automatic logic is_write(input logic [2:0] k);
      is_write = (k == des_pkg::DES_OP_WRITE) || (k == des_pkg::DES_OP_WVERIFY)
              || (k == des_pkg::DES_OP_READ_WRITE_TEST_OP);
   endfunction

   // True when the range runs past the last sector
   function automatic logic out_of_range(input logic [15:0] first, input logic [15:0] cnt);
      logic [16:0] sum;
      sum = {1'b0, first} + {1'b0, cnt};
      out_of_range = (sum > {1'b0, des_pkg::DISK_SECTORS});
   endfunction

   // Flag an error: stop now and go report
   function automatic des_ctrl_s fail(input des_ctrl_s s, input logic [3:0] num);
      fail       = s;
      fail.err   = num;
      fail.halt  = 1'b1;
      fail.fsm   = DES_FINISH;
   endfunction

   // Sequencer
   always_comb
   begin
      next_st          = st;
      next_st.done     = 1'b0;
      next_st.seek_req = 1'b0;
      next_st.sect_req = 1'b0;
      next_st.commit   = 1'b0;
      next_st.halt     = 1'b0;
      if ((st.fsm != DES_IDLE) && (st.fsm != DES_FINISH) && (tmr_expired || abort_nmi))
         next_st = fail(st, des_pkg::ERR_TIMEOUT);
      else
      begin
         unique case (st.fsm)
            DES_IDLE:
            begin
               // Latch parameters; status stays from last run
               if (op_start)
               begin
                  next_st.kind    = op_kind;
                  next_st.sector  = first_sector_number;
                  next_st.remain  = sector_count;
                  next_st.pointer = start_address;
                  next_st.tries   = 3'h0;
                  next_st.err     = des_pkg::ERR_NONE;
                  next_st.busy    = 1'b1;
                  next_st.fsm     = DES_CHECK;
               end
            end
            DES_CHECK:
            begin
               // Entry checks in order of priority
               if (!drive_ready)
                  next_st = fail(st, des_pkg::ERR_NREADY);
               else if (is_write(st.kind) && write_protect)
                  next_st = fail(st, des_pkg::ERR_WPROT);
               else if ((st.kind != des_pkg::DES_OP_HRETURN)
                        && out_of_range(st.sector, st.remain))
                  next_st = fail(st, des_pkg::ERR_BAD_ADDR);
               else
               begin
                  next_st.seek_req = 1'b1;
                  next_st.fsm      = DES_SEEK;
               end
            end
            DES_SEEK:
            begin
               // Track 0 before a seek ends is a fault, except on head return
               if ((st.kind != des_pkg::DES_OP_HRETURN) && track_zero && !seek_done)
                  next_st = fail(st, des_pkg::ERR_SEEK);
               else if (seek_done)
               begin
                  if (seek_fail)
                     next_st = fail(st, des_pkg::ERR_SEEK);
                  else if ((st.kind == des_pkg::DES_OP_HRETURN) || (st.remain == '0))
                     next_st.fsm = DES_FINISH;
                  else
                     next_st.fsm = DES_REQ;
               end
            end
            DES_REQ:
            begin
               // Start one attempt on the current sector
               next_st.sect_req = 1'b1;
               next_st.tries    = st.tries + 3'h1;
               next_st.fsm      = DES_WAIT;
            end
            DES_WAIT:
            begin
               // Judge the attempt
               if (sect_done)
               begin
                  if (sect_no_mark)
                  begin
                     if (st.tries >= des_pkg::READ_TRIES)
                        next_st = fail(st, des_pkg::ERR_NO_MARK);
                     else
                        next_st.fsm = DES_REQ;
                  end
                  else if (sect_deleted)
                     next_st = fail(st, des_pkg::ERR_DELETED);
                  else if (sect_crc_bad)
                  begin
                     if (st.tries >= des_pkg::READ_TRIES)
                        next_st = fail(st, des_pkg::ERR_DATA_CRC);
                     else
                        next_st.fsm = DES_REQ;
                  end
                  else
                  begin
                     // Good sector: accept and move on
                     next_st.commit  = 1'b1;
                     next_st.pointer = st.pointer + des_pkg::SECTOR_BYTES;
                     next_st.sector  = st.sector + 16'h0001;
                     next_st.remain  = st.remain - 16'h0001;
                     next_st.tries   = 3'h0;
                     next_st.fsm     = (st.remain == 16'h0001) ? DES_FINISH : DES_REQ;
                  end
               end
            end
            DES_FINISH:
            begin
               // Report result and release the host
               next_st.done = 1'b1;
               next_st.busy = 1'b0;
               next_st.fsm  = DES_IDLE;
            end
            default:
               next_st.fsm = DES_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end

   // Watchdog runs only while an operation is active
   des_tmr #(
      .CYCLES (TIMEOUT_CYCLES)
   ) u_tmr (
      .ref_clk (ref_clk),
      .srst    (srst),
      .run     (st.busy && (st.fsm != DES_FINISH)),
      .expired (tmr_expired)
   );

   // Status code holder, loads at the edge that raises op_done
   des_enc u_enc (
      .ref_clk     (ref_clk),
      .srst        (srst),
      .load        (st.fsm == DES_FINISH),
      .err_num     (st.err),
      .status_code (op_status_code),
      .carry       (carry_flag)
   );

   // Outputs straight from flip-flops, except sect_write decoded from the latched kind
   assign busy             = st.busy;
   assign op_done          = st.done;
   assign transfer_pointer = st.pointer;
   assign seek_req         = st.seek_req;
   assign sect_req         = st.sect_req;
   assign sect_addr        = st.sector;
   assign sect_write       = is_write(st.kind);
   assign sect_commit      = st.commit;
   assign op_halt          = st.halt;
endmodule

// ==== testbench/des_ctrl_checker.sv ====
// Purpose: Port-level assertions for the disk sequencer
// Assumes: One clock, srst synchronous active high
// Notes:   Bound onto every des_ctrl instance
`timescale 1ns/10ps
module des_ctrl_checker #(
   parameter int unsigned TIMEOUT_CYCLES = 200 // Watchdog cycles
) (
   input wire logic        ref_clk,             // Clock
   input wire logic        srst,                // Reset
   input wire logic        op_start,            // Start pulse
   input wire logic [2:0]  op_kind,             // Kind
   input wire logic [15:0] first_sector_number, // First sector
   input wire logic [15:0] sector_count,        // Count
   input wire logic        drive_ready,         // Ready
   input wire logic        write_protect,       // Protect
   input wire logic        sect_done,           // Attempt done
   input wire logic        sect_deleted,        // Deleted mark
   input wire logic        sect_crc_bad,        // Check bad
   input wire logic        sect_no_mark,        // No mark
   input wire logic        abort_nmi,           // Abort
   input wire logic        busy,                // Running
   input wire logic        op_done,             // Result pulse
   input wire logic [7:0]  op_status_code,      // Status
   input wire logic        carry_flag,          // Error flag
   input wire logic [15:0] transfer_pointer,    // Pointer
   input wire logic        sect_req,            // Attempt pulse
   input wire logic        sect_commit,         // Accepted
   input wire logic        seek_req,            // Seek pulse
   input wire logic        op_halt              // Stop pulse
);
   logic [7:0]  chk_code; // Code due from start checks, 0 if none
   logic [16:0] span;     // First sector plus count
   logic [2:0]  tries;    // Attempts on current sector
   int unsigned busy_cnt; // Busy cycles so far
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   assign span = {1'b0, first_sector_number} + {1'b0, sector_count};
   // Start checks, later lines win
   always_comb
   begin
      chk_code = 8'h00;
      if (op_kind != 3'h4 && span > {1'b0, des_pkg::DISK_SECTORS})
         chk_code = 8'h36;
      if (write_protect && (op_kind inside {3'h1, 3'h2, 3'h3}))
         chk_code = 8'h32;
      if (!drive_ready)
         chk_code = 8'h33;
   end
   // Attempt and busy counters
   always_ff @(posedge ref_clk)
   begin
      if (srst || seek_req || sect_commit)
         tries <= 3'h0;
      else if (sect_req)
         tries <= tries + 3'h1;
      busy_cnt <= (srst || !busy) ? 0 : busy_cnt + 1;
   end
   sequence s_crc_hit;
      sect_done && sect_crc_bad && !sect_deleted && !sect_no_mark && !abort_nmi;
   endsequence
   sequence s_del_hit;
      sect_done && sect_deleted && !sect_crc_bad && !sect_no_mark && !abort_nmi;
   endsequence
   a_code_carry: assert property (
      op_done |-> op_status_code inside {[8'h30:8'h38]}
      && carry_flag == (op_status_code != 8'h30)) else $error("bad code or carry");
   a_status_hold: assert property (
      !op_done && !$past(srst) |-> $stable(op_status_code) && $stable(carry_flag))
      else $error("status moved without a result");
   a_check_codes: assert property (
      op_start && !busy && !abort_nmi && chk_code != 8'h00 ##1 !abort_nmi
      |-> ##2 op_done && op_status_code == $past(chk_code, 3)) else $error("check code");
   a_abort_code: assert property (
      busy && abort_nmi |-> ##[1:3] (op_done && op_status_code == 8'h35))
      else $error("abort not reported");
   a_ptr_hold: assert property (
      busy && $past(busy) && !sect_commit |-> $stable(transfer_pointer))
      else $error("pointer moved without commit");
   a_deleted_stop: assert property (
      s_del_hit |-> ##1 (op_halt && !sect_commit) ##1 (op_done && op_status_code == 8'h34))
      else $error("deleted mark not stopped");
   a_crc_final: assert property (
      s_crc_hit and tries == 3'h5 |-> ##1 op_halt ##1 (op_done && op_status_code == 8'h31))
      else $error("data check not reported");
   a_crc_retry: assert property (
      s_crc_hit and tries < 3'h5 |-> ##2 sect_req) else $error("no retry");
   a_five_tries: assert property (
      op_done && (op_status_code == 8'h31 || op_status_code == 8'h38) |-> tries == 3'h5)
      else $error("wrong attempt count");
   a_watchdog_cap: assert property (
      busy |-> busy_cnt <= TIMEOUT_CYCLES + 2) else $error("watchdog overrun");
endmodule

bind des_ctrl des_ctrl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (.*);

// ==== testbench/des_disk_model.sv ====
// Purpose: Drive and data path stand-in for the sequencer
// Assumes: Requests are one-cycle pulses
// Notes:   Qualifiers toggle while their done pulse is low
`timescale 1ns/10ps
module des_disk_model (
   input  wire logic       ref_clk,      // Clock
   input  wire logic       srst,         // Reset
   input  wire logic       seek_req,     // Seek request
   input  wire logic       sect_req,     // Attempt request
   input  wire logic [3:0] delay,        // Answer wait
   input  wire logic [2:0] bad_tries,    // Failing attempts
   input  wire logic [1:0] fault,        // 1 crc, 2 no mark, 3 deleted
   input  wire logic       seek_bad,     // Seek faults
   input  wire logic       mute,         // Never answer
   output logic            seek_done,    // Seek done
   output logic            seek_fail,    // Seek fault
   output logic            sect_done,    // Attempt done
   output logic            sect_no_mark, // No mark
   output logic            sect_deleted, // Deleted mark
   output logic            sect_crc_bad  // Check bad
);
   logic [3:0] sk_cnt; // Seek countdown
   logic [3:0] sc_cnt; // Attempt countdown
   logic [2:0] tries;  // Attempts this operation
   logic       junk;   // Idle filler
   logic       bad;    // This attempt fails
   assign bad          = tries < bad_tries;
   assign seek_fail    = seek_done ? seek_bad : junk;
   assign sect_crc_bad = sect_done ? bad && fault == 2'h1 : junk;
   assign sect_no_mark = sect_done ? bad && fault == 2'h2 : ~junk;
   assign sect_deleted = sect_done ? bad && fault == 2'h3 : junk;
   // Answer each request after the set wait
   always_ff @(posedge ref_clk)
   begin
      junk      <= srst ? 1'b0 : ~junk;
      sk_cnt    <= (seek_req && !mute) ? delay : (sk_cnt != 4'h0 ? sk_cnt - 4'h1 : 4'h0);
      sc_cnt    <= (sect_req && !mute) ? delay : (sc_cnt != 4'h0 ? sc_cnt - 4'h1 : 4'h0);
      seek_done <= !srst && ((seek_req && !mute && delay == 4'h0) || sk_cnt == 4'h1);
      sect_done <= !srst && ((sect_req && !mute && delay == 4'h0) || sc_cnt == 4'h1);
      tries     <= (srst || seek_req) ? 3'h0 : tries + {2'h0, sect_done};
   end
endmodule

// ==== testbench/disk_error_status_encoder_tb.sv ====
// Purpose: Self-checking bench for the disk sequencer
// Assumes: Watchdog shortened to 200 cycles
// Notes:   Table rows, then busy, hold, abort, watchdog and reset cases
`timescale 1ns/10ps
module disk_error_status_encoder_tb;
   localparam int unsigned TMO = 200; // Short watchdog
   typedef struct packed {
      logic [2:0] kind; logic [15:0] first; logic [15:0] cnt; logic rdy; logic wp;
      logic tz; logic sbad; logic [3:0] dly; logic [1:0] flt; logic [2:0] bad;
      logic [7:0] code; logic [15:0] ptr;
   } des_row_s;
   logic ref_clk = 1'b0, srst = 1'b1, op_start = 1'b0, abort_nmi = 1'b0, mute = 1'b0;
   des_row_s cur = '0; // Row being driven
   int error_cnt = 0, checks = 0, cyc = 0;
   logic seek_done, seek_fail, sect_done, sect_no_mark, sect_deleted, sect_crc_bad;
   logic busy, op_done, carry_flag, seek_req, sect_req, sect_commit, op_halt;
   logic [7:0] op_status_code; // Status
   logic [15:0] transfer_pointer; // Pointer
   des_row_s rows [15] = '{
      {3'h0, 16'h0, 16'h1, 4'b1000, 4'h0, 2'h0, 3'h0, 8'h30, 16'h1080},
      {3'h1, 16'h7D0, 16'h2, 4'b1000, 4'h2, 2'h0, 3'h0, 8'h30, 16'h1100},
      {3'h1, 16'h0, 16'h1, 4'b1100, 4'h0, 2'h0, 3'h0, 8'h32, 16'h1000},
      {3'h0, 16'h0, 16'h1, 4'b0000, 4'h0, 2'h0, 3'h0, 8'h33, 16'h1000},
      {3'h0, 16'h7D0, 16'h3, 4'b1000, 4'h0, 2'h0, 3'h0, 8'h36, 16'h1000},
      {3'h4, 16'h7D0, 16'h5, 4'b1000, 4'h0, 2'h0, 3'h0, 8'h30, 16'h1000},
      {3'h0, 16'h5, 16'h1, 4'b1000, 4'h1, 2'h1, 3'h4, 8'h30, 16'h1080},
      {3'h0, 16'h5, 16'h1, 4'b1000, 4'h0, 2'h1, 3'h5, 8'h31, 16'h1000},
      {3'h0, 16'h5, 16'h1, 4'b1000, 4'h0, 2'h2, 3'h5, 8'h38, 16'h1000},
      {3'h0, 16'h5, 16'h1, 4'b1000, 4'h0, 2'h3, 3'h1, 8'h34, 16'h1000},
      {3'h3, 16'h5, 16'h1, 4'b1001, 4'h0, 2'h0, 3'h0, 8'h37, 16'h1000},
      {3'h0, 16'h5, 16'h1, 4'b1010, 4'h3, 2'h0, 3'h0, 8'h37, 16'h1000},
      {3'h0, 16'h5, 16'h0, 4'b1000, 4'h0, 2'h0, 3'h0, 8'h30, 16'h1000},
      {3'h2, 16'h9, 16'h1, 4'b1000, 4'h0, 2'h1, 3'h5, 8'h31, 16'h1000},
      {3'h1, 16'h9, 16'h1, 4'b1000, 4'h0, 2'h0, 3'h0, 8'h30, 16'h1080}
   };
   // Clock, 25 ns period
   always #12.5 ref_clk = ~ref_clk;
   des_ctrl #(.TIMEOUT_CYCLES(TMO)) i_dut (.ref_clk(ref_clk), .srst(srst),
      .op_start(op_start), .op_kind(cur.kind), .first_sector_number(cur.first),
      .sector_count(cur.cnt), .start_address(16'h1000), .drive_ready(cur.rdy),
      .write_protect(cur.wp), .track_zero(cur.tz), .seek_done(seek_done),
      .seek_fail(seek_fail), .sect_done(sect_done), .sect_no_mark(sect_no_mark),
      .sect_deleted(sect_deleted), .sect_crc_bad(sect_crc_bad), .abort_nmi(abort_nmi),
      .busy(busy), .op_done(op_done), .op_status_code(op_status_code),
      .carry_flag(carry_flag), .transfer_pointer(transfer_pointer), .seek_req(seek_req),
      .sect_req(sect_req), .sect_addr(), .sect_write(), .sect_commit(sect_commit),
      .op_halt(op_halt));
   des_disk_model i_disk (.ref_clk(ref_clk), .srst(srst), .seek_req(seek_req),
      .sect_req(sect_req), .delay(cur.dly), .bad_tries(cur.bad), .fault(cur.flt),
      .seek_bad(cur.sbad), .mute(mute), .seek_done(seek_done), .seek_fail(seek_fail),
      .sect_done(sect_done), .sect_no_mark(sect_no_mark), .sect_deleted(sect_deleted),
      .sect_crc_bad(sect_crc_bad));
   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // One comparison
   task automatic expect16(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Result code, carry and pointer
   task automatic check_res(input logic [7:0] code, input logic [15:0] ptr);
      expect16({8'h00, op_status_code}, {8'h00, code}, "code");
      expect16({15'h0, carry_flag}, {15'h0, code != 8'h30}, "carry");
      expect16(transfer_pointer, ptr, "pointer");
   endtask
   // Start one operation, optional stray start or abort, wait for result
   task automatic run_op(input des_row_s r, input logic dup, input logic ab);
      for (cyc = 0; cyc < 300; cyc++)
      begin
         @(posedge ref_clk);
         op_start  <= cyc == 0 || (dup && cyc == 4);
         abort_nmi <= ab && cyc == 8;
         cur       <= r;
         if (dup && cyc == 4)
            cur.kind <= 3'h4;
         @(negedge ref_clk);
         if (cyc > 0 && op_done === 1'b1)
            break;
      end
      if (cyc == 300)
      begin
         expect16(16'h0, 16'h1, "no result");
         conclude();
      end
   endtask
   // Main sequence
   initial
   begin
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      expect16({15'h0, busy}, 16'h0, "busy in reset");
      check_res(8'h30, 16'h0000);
      srst <= 1'b0;
      for (int i = 0; i < 15; i++)
      begin
         run_op(rows[i], 1'b0, 1'b0);
         check_res(rows[i].code, rows[i].ptr);
         $display("row %0d done", i);
      end
      run_op(rows[0], 1'b1, 1'b0);
      check_res(8'h30, 16'h1080);
      $display("stray start test done");
      run_op(rows[7], 1'b0, 1'b0);
      repeat (10) @(negedge ref_clk);
      check_res(8'h31, 16'h1000);
      $display("hold test done");
      mute = 1'b1;
      run_op(rows[0], 1'b0, 1'b1);
      check_res(8'h35, 16'h1000);
      $display("abort test done");
      run_op(rows[0], 1'b0, 1'b0);
      check_res(8'h35, 16'h1000);
      expect16({15'h0, cyc >= TMO}, 16'h1, "watchdog early");
      $display("watchdog test done");
      mute = 1'b0;
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      check_res(8'h30, 16'h0000);
      run_op(rows[1], 1'b0, 1'b0);
      check_res(8'h30, 16'h1100);
      $display("second reset test done");
      conclude();
   end
endmodule
